// ==== rtl/servo_assist_pkg.sv ====
package servo_assist_pkg;

  // Data widths
  localparam int DW  = 16;               // Torque / speed / threshold width
  localparam int AW  = 4;                // Register index width
  localparam int RDW = 32;               // Register data width

  // Register indices
  localparam logic [AW-1:0] ADDR_CFG      = 4'h0;  // Restart-latched selectors
  localparam logic [AW-1:0] ADDR_TRQ_THR  = 4'h1;
  localparam logic [AW-1:0] ADDR_DEV_THR  = 4'h2;
  localparam logic [AW-1:0] ADDR_ACC_THR  = 4'h3;
  localparam logic [AW-1:0] ADDR_SPD_THR  = 4'h4;
  localparam logic [AW-1:0] ADDR_SFF_GAIN = 4'h5;
  localparam logic [AW-1:0] ADDR_SFF_TIME = 4'h6;
  localparam logic [AW-1:0] ADDR_TFF_GAIN = 4'h7;
  localparam logic [AW-1:0] ADDR_TFF_TIME = 4'h8;
  localparam logic [AW-1:0] ADDR_COUL_LVL = 4'h9;
  localparam logic [AW-1:0] ADDR_COUL_DB  = 4'ha;
  localparam logic [AW-1:0] ADDR_VISC     = 4'hb;
  localparam logic [AW-1:0] ADDR_INERTIA  = 4'hc;
  localparam logic [AW-1:0] ADDR_STATUS   = 4'hd;

  // Config field positions in ADDR_CFG
  localparam int CFG_MODE_LSB = 0;       // 3 bits switch mode
  localparam int CFG_SFF_LSB  = 4;       // 2 bits speed ff source
  localparam int CFG_TFF_LSB  = 6;       // 2 bits torque ff source
  localparam int CFG_VAR_LSB  = 8;       // 2 bits torque ff variant
  localparam int CFG_MFC_LSB  = 10;      // 2 bits model following enable

  // Reset values
  localparam logic [DW-1:0] TRQ_THR_RST = 16'h00c8;   // 200 percent
  localparam logic [DW-1:0] ZERO        = 16'h0000;
  localparam logic [DW-1:0] GAIN_RST    = 16'h0000;
  localparam logic [DW-1:0] INERTIA_RST = 16'h0064;   // 100 percent
  localparam logic [3:0]    TIME_RST    = 4'h0;
  localparam logic [DW-1:0] INTERP_CUBIC = 16'hffff;  // Sub-mode -1
  localparam int PCT_SHIFT  = 7;         // Percent gain as Q7 scale
  localparam int GAIN_SHIFT = 7;

  // Switch mode decode
  typedef enum logic [2:0] {
    SW_TORQUE, SW_DEVIATION, SW_ACCEL, SW_SPEED, SW_FIXED_PI
  } sw_mode_e;

  // Feedforward source decode
  typedef enum logic [1:0] {
    FF_INTERNAL, FF_MODEL, FF_HOST, FF_CUBIC
  } ff_src_e;

  // Restart-latched configuration, laid out bit for bit as the CFG word
  typedef struct packed {
    logic [1:0] mfc_en;
    logic [1:0] tff_var;
    ff_src_e    tff_src;
    ff_src_e    sff_src;
    logic       rsv;                     // Spare bit 3, keeps sources on bits 7:4
    sw_mode_e   sw_mode;
  } cfg_s;

  // Loop quantities sampled each control cycle
  typedef struct packed {
    logic signed [DW-1:0] trq_ref;
    logic signed [DW-1:0] pos_dev;
    logic signed [DW-1:0] acc_ref;
    logic signed [DW-1:0] spd_ref;
  } loop_q_s;

endpackage

// ==== rtl/ff_lowpass.sv ====
`timescale 1ns/1ps
// First order low-pass: y += (x - y) >>> shift
module ff_lowpass
  import servo_assist_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 en,
  input  wire logic [3:0]           shift,
  input  wire logic signed [DW-1:0] x,
  output logic signed [DW-1:0]      y
);

  logic signed [DW:0] diff;               // Widened error term

  // Error between input and state
  always_comb
  begin
    diff = {x[DW-1], x} - {y[DW-1], y};
  end

  // Filter state, zero shift passes input straight
  always_ff @(posedge clk)
  begin
    if (srst)
      y <= ZERO;
    else if (en)
      y <= DW'(y + DW'(diff >>> shift));
  end

endmodule

// ==== rtl/pi_switch_cond.sv ====
`timescale 1ns/1ps
// Decides P-only action from selected quantity and threshold
module pi_switch_cond
  import servo_assist_pkg::*;
(
  input  wire sw_mode_e         mode,
  input  wire loop_q_s          q,
  input  wire logic [DW-1:0]    trq_thr,
  input  wire logic [DW-1:0]    dev_thr,
  input  wire logic [DW-1:0]    acc_thr,
  input  wire logic [DW-1:0]    spd_thr,
  output logic                  p_only
);

  // Magnitude of a signed quantity
  function automatic logic [DW-1:0] mag(input logic signed [DW-1:0] v);
    mag = v[DW-1] ? DW'(-v) : v;
  endfunction

  // Strictly greater than threshold gives P-only
  always_comb
  begin
    case (mode)
      SW_TORQUE:    p_only = mag(q.trq_ref) > trq_thr;
      SW_DEVIATION: p_only = mag(q.pos_dev) > dev_thr;
      SW_ACCEL:     p_only = mag(q.acc_ref) > acc_thr;
      SW_SPEED:     p_only = mag(q.spd_ref) > spd_thr;
      default:      p_only = 1'b0;
    endcase
  end

endmodule

// ==== rtl/servo_assist.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Contract
// - PI by default, P only on condition
// - Mode 0..3 compare, 4 fixed PI, restart
// - Modes 0..3: P while quantity exceeds threshold
// - Mode 4 always PI
// - Four thresholds, effective immediately
// - Torque threshold default 200, strictly greater
// - Speed ff source 0..3, after restart
// - Torque ff source 0..3, after restart
// - Host offsets only under fieldbus control
// - Cubic needs fieldbus and sub-mode -1
// - Speed ff = dPos times gain
// - Torque ff = dSpeed times inertia times gain; code halves dSpeed in every variant except 2
// - Both ff low-pass filtered, own times
// - Variant 0 general, 2 high speed
// - Coulomb magnitude setting, sign of speed
// - Coulomb zero inside speed dead band
// - Viscous proportional to speed
module servo_assist
  import servo_assist_pkg::*;
(
  input  wire logic                 CLK_SYS,
  input  wire logic                 SRST,
  input  wire logic                 CTRL_TICK,      // Control cycle enable pulse
  input  wire logic                 RESTART,        // Latch restart settings
  input  wire logic                 BUS_CTRL,       // Fieldbus control active
  input  wire logic [AW-1:0]        REG_ADDR,
  input  wire logic [RDW-1:0]       REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic [RDW-1:0]            REG_RDATA,
  input  wire loop_q_s              LOOP_Q,         // Compared quantities
  input  wire logic signed [DW-1:0] POS_REF,
  input  wire logic signed [DW-1:0] SPD_FB,
  input  wire logic signed [DW-1:0] KP_ERR,         // Proportional term
  input  wire logic signed [DW-1:0] KI_ERR,         // Integral increment
  input  wire logic signed [DW-1:0] MFC_SPD_FF,
  input  wire logic signed [DW-1:0] MFC_TRQ_FF,
  input  wire logic signed [31:0]   HOST_VEL_OFS,   // Signed 32-bit velocity offset
  input  wire logic signed [DW-1:0] HOST_TRQ_OFS,   // Signed 16-bit torque offset
  input  wire logic signed [DW-1:0] INTERP_SUBMODE,
  input  wire logic signed [DW-1:0] CUBIC_SPD_FF,
  input  wire logic signed [DW-1:0] CUBIC_TRQ_FF,
  output logic signed [DW-1:0]      SPD_FF,
  output logic signed [DW-1:0]      TRQ_REF,
  output logic                      P_ONLY
);

  ////////////////////////////////////////////////////////////////////////////////
  // Settings
  cfg_s                 cfg_pend;       // Written, awaiting restart
  cfg_s                 cfg;            // Active selectors
  logic [DW-1:0]        trq_thr;
  logic [DW-1:0]        dev_thr;
  logic [DW-1:0]        acc_thr;
  logic [DW-1:0]        spd_thr;
  logic signed [DW-1:0] sff_gain;
  logic [3:0]           sff_time;
  logic signed [DW-1:0] tff_gain;
  logic [3:0]           tff_time;
  logic [DW-1:0]        coul_lvl;
  logic [DW-1:0]        coul_db;
  logic signed [DW-1:0] visc;
  logic [DW-1:0]        inertia;

  // Loop state
  logic signed [DW-1:0] pos_prev;       // Previous position reference
  logic signed [DW-1:0] spd_prev;       // Previous speed reference
  logic signed [DW-1:0] integ;          // Speed loop integrator
  logic signed [DW-1:0] sff_raw;        // Selected speed ff
  logic signed [DW-1:0] tff_raw;        // Selected torque ff
  logic signed [DW-1:0] sff_filt;
  logic signed [DW-1:0] tff_filt;
  logic signed [DW-1:0] next_sff_int;
  logic signed [DW-1:0] next_tff_int;
  logic signed [DW-1:0] coul;
  logic signed [DW-1:0] visc_term;
  logic                 p_only;
  logic [DW-1:0]        spd_mag;
  logic signed [2*DW-1:0] prod_s;
  logic signed [3*DW-1:0] prod_t;
  logic signed [2*DW-1:0] prod_v;
  logic                 cubic_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes, thresholds and gains act at once
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      cfg_pend <= '0;
      trq_thr  <= TRQ_THR_RST;
      dev_thr  <= ZERO;
      acc_thr  <= ZERO;
      spd_thr  <= ZERO;
      sff_gain <= GAIN_RST;
      sff_time <= TIME_RST;
      tff_gain <= GAIN_RST;
      tff_time <= TIME_RST;
      coul_lvl <= ZERO;
      coul_db  <= ZERO;
      visc     <= ZERO;
      inertia  <= INERTIA_RST;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == ADDR_CFG)
        cfg_pend <= cfg_s'(REG_WDATA[$bits(cfg_s)-1:0]);
      else if (REG_ADDR == ADDR_TRQ_THR)
        trq_thr <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_DEV_THR)
        dev_thr <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_ACC_THR)
        acc_thr <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_SPD_THR)
        spd_thr <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_SFF_GAIN)
        sff_gain <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_SFF_TIME)
        sff_time <= REG_WDATA[3:0];
      else if (REG_ADDR == ADDR_TFF_GAIN)
        tff_gain <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_TFF_TIME)
        tff_time <= REG_WDATA[3:0];
      else if (REG_ADDR == ADDR_COUL_LVL)
        coul_lvl <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_COUL_DB)
        coul_db <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_VISC)
        visc <= REG_WDATA[DW-1:0];
      else if (REG_ADDR == ADDR_INERTIA)
        inertia <= REG_WDATA[DW-1:0];
    end
  end

  // Restart-effective selectors copied on restart only
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      cfg <= '0;
    else if (RESTART)
      cfg <= cfg_pend;
  end

  // Read data, one cycle after strobe; zero otherwise
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      REG_RDATA <= '0;
    else if (!REG_RD)
      REG_RDATA <= '0;
    else if (REG_ADDR == ADDR_CFG)
      REG_RDATA <= RDW'(cfg_pend);
    else if (REG_ADDR == ADDR_TRQ_THR)
      REG_RDATA <= RDW'(trq_thr);
    else if (REG_ADDR == ADDR_DEV_THR)
      REG_RDATA <= RDW'(dev_thr);
    else if (REG_ADDR == ADDR_ACC_THR)
      REG_RDATA <= RDW'(acc_thr);
    else if (REG_ADDR == ADDR_SPD_THR)
      REG_RDATA <= RDW'(spd_thr);
    else if (REG_ADDR == ADDR_SFF_GAIN)
      REG_RDATA <= RDW'(sff_gain);
    else if (REG_ADDR == ADDR_SFF_TIME)
      REG_RDATA <= RDW'(sff_time);
    else if (REG_ADDR == ADDR_TFF_GAIN)
      REG_RDATA <= RDW'(tff_gain);
    else if (REG_ADDR == ADDR_TFF_TIME)
      REG_RDATA <= RDW'(tff_time);
    else if (REG_ADDR == ADDR_COUL_LVL)
      REG_RDATA <= RDW'(coul_lvl);
    else if (REG_ADDR == ADDR_COUL_DB)
      REG_RDATA <= RDW'(coul_db);
    else if (REG_ADDR == ADDR_VISC)
      REG_RDATA <= RDW'(visc);
    else if (REG_ADDR == ADDR_INERTIA)
      REG_RDATA <= RDW'(inertia);
    else if (REG_ADDR == ADDR_STATUS)
      REG_RDATA <= {{(RDW-$bits(cfg_s)-1){1'b0}}, p_only, cfg};    // Active state
    else
      REG_RDATA <= '0;                                             // Unmapped
  end

  ////////////////////////////////////////////////////////////////////////////////
  // P/PI decision
  pi_switch_cond u_cond (
    .mode    (cfg.sw_mode),
    .q       (LOOP_Q),
    .trq_thr (trq_thr),
    .dev_thr (dev_thr),
    .acc_thr (acc_thr),
    .spd_thr (spd_thr),
    .p_only  (p_only)
  );

  // Integrator holds in P-only mode
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      integ <= ZERO;
    else if (CTRL_TICK && !p_only)
      integ <= DW'(integ + KI_ERR);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal feedforward from reference derivatives
  always_comb
  begin
    prod_s = DW'(POS_REF - pos_prev) * sff_gain;
    next_sff_int = DW'(prod_s >>> GAIN_SHIFT);
    // High-speed variant uses the full reference speed difference, other variants halve it
    if (cfg.tff_var == 2'h2)
      prod_t = DW'(LOOP_Q.spd_ref - spd_prev) * $signed({1'b0, inertia}) * tff_gain;
    else
      prod_t = DW'(DW'(LOOP_Q.spd_ref - spd_prev) >>> 1) * $signed({1'b0, inertia})
               * tff_gain;
    next_tff_int = DW'(prod_t >>> (PCT_SHIFT + GAIN_SHIFT));
  end

  // Reference history for differentiation
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      pos_prev <= ZERO;
      spd_prev <= ZERO;
    end
    else if (CTRL_TICK)
    begin
      pos_prev <= POS_REF;
      spd_prev <= LOOP_Q.spd_ref;
    end
  end

  // Source selection, bus sources fall back to zero off-bus
  assign cubic_ok = BUS_CTRL && (INTERP_SUBMODE == INTERP_CUBIC);

  always_comb
  begin
    case (cfg.sff_src)
      FF_INTERNAL: sff_raw = next_sff_int;
      FF_MODEL:    sff_raw = MFC_SPD_FF;
      FF_HOST:     sff_raw = BUS_CTRL ? HOST_VEL_OFS[DW-1:0] : ZERO;
      default:     sff_raw = cubic_ok ? CUBIC_SPD_FF : ZERO;
    endcase
    case (cfg.tff_src)
      FF_INTERNAL: tff_raw = next_tff_int;
      FF_MODEL:    tff_raw = MFC_TRQ_FF;
      FF_HOST:     tff_raw = BUS_CTRL ? HOST_TRQ_OFS : ZERO;
      default:     tff_raw = cubic_ok ? CUBIC_TRQ_FF : ZERO;
    endcase
  end

  // Feedforward filters
  ff_lowpass u_sff_lp (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .en    (CTRL_TICK),
    .shift (sff_time),
    .x     (sff_raw),
    .y     (sff_filt)
  );

  ff_lowpass u_tff_lp (
    .clk   (CLK_SYS),
    .srst  (SRST),
    .en    (CTRL_TICK),
    .shift (tff_time),
    .x     (tff_raw),
    .y     (tff_filt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Friction compensation
  always_comb
  begin
    spd_mag   = SPD_FB[DW-1] ? DW'(-SPD_FB) : SPD_FB;
    prod_v    = SPD_FB * visc;
    visc_term = DW'(prod_v >>> GAIN_SHIFT);
    if (spd_mag <= coul_db)
      coul = ZERO;
    else if (SPD_FB[DW-1])
      coul = DW'(-$signed(coul_lvl));
    else
      coul = $signed(coul_lvl);
  end

  // Outputs registered on each control tick
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      SPD_FF  <= ZERO;
      TRQ_REF <= ZERO;
      P_ONLY  <= 1'b0;
    end
    else if (CTRL_TICK)
    begin
      SPD_FF  <= sff_filt;
      TRQ_REF <= DW'(KP_ERR + (p_only ? integ : DW'(integ + KI_ERR))
                 + tff_filt + coul + visc_term);
      P_ONLY  <= p_only;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  fixed_pi_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CTRL_TICK && cfg.sw_mode == SW_FIXED_PI |=> !P_ONLY)
    else $error("P-only in fixed PI mode");
  integ_hold_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    p_only |=> $stable(integ))
    else $error("Integrator moved in P-only mode");
  trq_thr_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CTRL_TICK && cfg.sw_mode == SW_TORQUE && !LOOP_Q.trq_ref[DW-1]
    && LOOP_Q.trq_ref <= $signed(trq_thr) |=> !P_ONLY)
    else $error("P-only at or below torque threshold");
  dead_band_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    spd_mag <= coul_db |-> coul == ZERO)
    else $error("Coulomb term inside dead band");
  coul_sign_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    spd_mag > coul_db && coul_lvl != ZERO |-> coul[DW-1] == SPD_FB[DW-1])
    else $error("Coulomb sign wrong");
  cfg_hold_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !RESTART |=> $stable(cfg))
    else $error("Selector changed without restart");
  host_off_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    cfg.tff_src == FF_HOST && !BUS_CTRL |-> tff_raw == ZERO)
    else $error("Host offset used off-bus");
  cubic_gate_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    cfg.sff_src == FF_CUBIC && !cubic_ok |-> sff_raw == ZERO)
    else $error("Cubic ff used without sub-mode");
  rd_zero_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
    !REG_RD |=> REG_RDATA == '0)
    else $error("Read data outside read cycle");
  p_mode_c: cover property (@(posedge CLK_SYS) CTRL_TICK ##1 P_ONLY);
  restart_c: cover property (@(posedge CLK_SYS) RESTART && cfg_pend != cfg);
  coul_c: cover property (@(posedge CLK_SYS) coul != ZERO);

endmodule

// ==== verification/fieldbus_host_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host controller side: holds the process objects the drive reads
module fieldbus_host_model
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          obj_wr,    // Object write strobe
  input  wire logic [1:0]    obj_sel,   // 0 bus mode, 1 vel, 2 torque, 3 sub-mode
  input  wire logic [31:0]   obj_val,   // Object value
  output logic               bus_ctrl,  // Fieldbus control active
  output logic signed [31:0] vel_ofs,   // Velocity offset object
  output logic signed [15:0] trq_ofs,   // Torque offset object
  output logic signed [15:0] submode    // Interpolation sub-mode object
);
  ////////////////////////////////////////////////////////////////////////////////
  // Objects fall back to local control after reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      bus_ctrl <= 1'b0;
      vel_ofs  <= 32'h0;
      trq_ofs  <= 16'h0;
      submode  <= 16'h0;
    end
    else if (obj_wr)
    begin
      case (obj_sel)
        2'h0:    bus_ctrl <= obj_val[0];
        2'h1:    vel_ofs  <= obj_val;
        2'h2:    trq_ofs  <= obj_val[15:0];
        default: submode  <= obj_val[15:0];
      endcase
    end
  end
endmodule

// ==== verification/tb_servo_assist.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Bench for the speed loop helper
module tb_servo_assist
  import servo_assist_pkg::*;
;
  logic                 clk, srst, tick, restart, reg_wr, reg_rd, p_only;  // Control
  logic [AW-1:0]        reg_addr;                         // Register index
  logic [RDW-1:0]       reg_wdata, reg_rdata, rv;         // Register data
  loop_q_s              loop_q;                           // Compared quantities
  logic signed [DW-1:0] pos_ref, spd_fb, kp, ki, a;       // Loop inputs
  logic signed [DW-1:0] mfc_s, mfc_t, cub_s, cub_t;       // Alternate ff sources
  logic signed [DW-1:0] spd_ff, trq_ref, trq_ofs, submode;
  logic signed [31:0]   vel_ofs;                          // Host velocity offset
  logic                 bus_ctrl, obj_wr;                 // Host objects
  logic [1:0]           obj_sel;
  logic [31:0]          obj_val;
  int                   error_cnt, comparisons;           // Verdict counters

  servo_assist servo_assist_i (.CLK_SYS(clk), .SRST(srst), .CTRL_TICK(tick),
    .RESTART(restart), .BUS_CTRL(bus_ctrl), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LOOP_Q(loop_q),
    .POS_REF(pos_ref), .SPD_FB(spd_fb), .KP_ERR(kp), .KI_ERR(ki), .MFC_SPD_FF(mfc_s),
    .MFC_TRQ_FF(mfc_t), .HOST_VEL_OFS(vel_ofs), .HOST_TRQ_OFS(trq_ofs),
    .INTERP_SUBMODE(submode), .CUBIC_SPD_FF(cub_s), .CUBIC_TRQ_FF(cub_t),
    .SPD_FF(spd_ff), .TRQ_REF(trq_ref), .P_ONLY(p_only));

  fieldbus_host_model fieldbus_host_model_i (.clk(clk), .srst(srst), .obj_wr(obj_wr),
    .obj_sel(obj_sel), .obj_val(obj_val), .bus_ctrl(bus_ctrl), .vel_ofs(vel_ofs),
    .trq_ofs(trq_ofs), .submode(submode));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task stop_test();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles used
  initial
  begin
    #(25 * 40000);
    error_cnt++;
    stop_test();
  end

  // One comparison
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus, host objects, control ticks
  task wr(input logic [AW-1:0] ad, input logic [RDW-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task rd(input logic [AW-1:0] ad);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= ad;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task obj(input logic [1:0] s, input logic [31:0] v);
    @(posedge clk);
    obj_wr <= 1'b1; obj_sel <= s; obj_val <= v;
    @(posedge clk);
    obj_wr <= 1'b0;
  endtask

  // Restart-effective settings
  task cfg(input logic [RDW-1:0] v);
    wr(ADDR_CFG, v);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask

  // Back-to-back ticks with position and speed reference ramps
  task run(input int n, input logic signed [DW-1:0] dp, input logic signed [DW-1:0] ds);
    repeat (n)
    begin
      @(posedge clk);
      tick <= 1'b1; pos_ref <= pos_ref + dp; loop_q.spd_ref <= loop_q.spd_ref + ds;
    end
    @(posedge clk);
    tick <= 1'b0;
    #1;
  endtask

  task do_reset();
    @(posedge clk);
    srst <= 1'b1; loop_q <= '0; pos_ref <= 16'h0; spd_fb <= 16'h0; kp <= 16'h0; ki <= 16'h0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_regs();
    rd(ADDR_TRQ_THR); chk(rv, 32'h000000c8);
    rd(ADDR_INERTIA); chk(rv, 32'h00000064);
    rd(ADDR_CFG);     chk(rv, 32'h0);
    wr(ADDR_STATUS, 32'h0000ffff);
    rd(ADDR_STATUS);  chk(rv, 32'h0);
    rd(4'he);         chk(rv, 32'h0);
  endtask

  // Torque condition, strictly greater, magnitude, live threshold
  task t_torque();
    loop_q.trq_ref <= 16'h00c8; run(2, 0, 0); chk(p_only, 1'b0);
    loop_q.trq_ref <= 16'h00c9; run(2, 0, 0); chk(p_only, 1'b1);
    loop_q.trq_ref <= 16'hff37; run(2, 0, 0); chk(p_only, 1'b1);
    loop_q.trq_ref <= 16'h00c8; run(2, 0, 0); chk(p_only, 1'b0);
    wr(ADDR_TRQ_THR, 32'h12c);
    loop_q.trq_ref <= 16'h00c9; run(2, 0, 0); chk(p_only, 1'b0);
  endtask

  // Other conditions ignore the torque reference; mode 4 waits for restart
  task t_modes();
    wr(ADDR_DEV_THR, 32'h64); wr(ADDR_ACC_THR, 32'h64); wr(ADDR_SPD_THR, 32'h64);
    for (int m = 1; m < 4; m++)
    begin
      cfg(m);
      // Whole word in one write: torque high, selected quantity just above
      loop_q <= {16'h012c, 48'h0} | (64'h65 << ((3 - m) * 16));
      run(2, 0, 0);
      chk(p_only, 1'b1);
      loop_q <= {16'h012c, 48'h0} | (64'h64 << ((3 - m) * 16));
      run(2, 0, 0);
      chk(p_only, 1'b0);
    end
    wr(ADDR_CFG, 32'h4);
    loop_q <= {4{16'h012c}};
    run(2, 0, 0);
    chk(p_only, 1'b1);
    rd(ADDR_CFG);
    chk(rv, 32'h4);
    rd(ADDR_STATUS);
    chk(rv, 32'h1003);
    cfg(32'h4);
    run(2, 0, 0);
    chk(p_only, 1'b0);
    rd(ADDR_STATUS);
    chk(rv, 32'h4);
  endtask

  // Integrator advances in PI and holds in P-only
  task t_integ();
    kp <= 16'h000a; ki <= 16'h0005;
    run(2, 0, 0); a = trq_ref;
    run(1, 0, 0); chk(trq_ref - a, 32'h5);
    loop_q.trq_ref <= 16'h00c9; run(1, 0, 0); a = trq_ref;
    run(2, 0, 0); chk(trq_ref, a);
    chk(p_only, 1'b1);
    loop_q.trq_ref <= 16'h0000; run(1, 0, 0); a = trq_ref;
    run(1, 0, 0); chk(trq_ref - a, 32'h5);
  endtask

  // Coulomb with dead band, viscous, and their sum
  task t_friction();
    wr(ADDR_COUL_LVL, 32'h32); wr(ADDR_COUL_DB, 32'h14);
    spd_fb <= 16'h0064; run(2, 0, 0); chk(trq_ref, 32'h32);
    spd_fb <= 16'hff9c; run(2, 0, 0); chk(trq_ref, -32'sd50);
    spd_fb <= 16'h000a; run(2, 0, 0); chk(trq_ref, 32'h0);
    spd_fb <= 16'hfff6; run(2, 0, 0); chk(trq_ref, 32'h0);
    wr(ADDR_COUL_LVL, 32'h0); wr(ADDR_VISC, 32'h80);
    spd_fb <= 16'h0040; run(2, 0, 0); chk(trq_ref, 32'h40);
    spd_fb <= 16'hffc0; run(2, 0, 0); chk(trq_ref, -32'sd64);
    wr(ADDR_COUL_LVL, 32'h32);
    spd_fb <= 16'h0064; run(2, 0, 0); chk(trq_ref, 32'h96);
  endtask

  // Internal feedforward, filter lag, torque variants
  task t_ff_int();
    wr(ADDR_SFF_GAIN, 32'h80); wr(ADDR_TFF_GAIN, 32'h80); wr(ADDR_INERTIA, 32'h80);
    run(5, 16'h000a, 0); chk(spd_ff, 32'h0a);
    wr(ADDR_SFF_TIME, 32'h3);
    // Shift 3 from 10 toward 20: state 11, 12, 13; output lags one tick
    run(3, 16'h0014, 0); chk(spd_ff, 32'h0c);
    cfg(32'h200); run(5, 0, 16'h0008); chk(trq_ref, 32'h8);
    cfg(32'h0);   run(5, 0, 16'h0008); chk(trq_ref, 32'h4);
  endtask

  // Model, host and cubic sources, and their gating
  task t_ff_src();
    wr(ADDR_SFF_GAIN, 32'h80); wr(ADDR_TFF_GAIN, 32'h80); wr(ADDR_INERTIA, 32'h80);
    mfc_s <= 16'h0021; mfc_t <= 16'h0022; cub_s <= 16'h0037; cub_t <= 16'h0038;
    obj(2'h1, 32'h2c); obj(2'h2, 32'h2d); obj(2'h3, 32'hffff); obj(2'h0, 32'h1);
    for (int s = 1; s < 4; s++)
    begin
      cfg(s << 4 | s << 6 | 1 << 10);
      run(4, 0, 0);
      chk(spd_ff, s == 1 ? 32'h21 : s == 2 ? 32'h2c : 32'h37);
      chk(trq_ref, s == 1 ? 32'h22 : s == 2 ? 32'h2d : 32'h38);
    end
    // Active selectors: both sources cubic, model following on
    rd(ADDR_STATUS);
    chk(rv, 32'h4f0);
    obj(2'h3, 32'h0); run(4, 0, 0); chk(spd_ff, 32'h0);
    chk(trq_ref, 32'h0);
    obj(2'h3, 32'hffff); obj(2'h0, 32'h0); run(4, 0, 0); chk(spd_ff, 32'h0);
    cfg(32'ha0); run(4, 0, 0); chk(spd_ff, 32'h0);
    chk(trq_ref, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    srst = 1'b1; tick = 1'b0; restart = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = '0; reg_wdata = '0; loop_q = '0; pos_ref = '0; spd_fb = '0;
    kp = '0; ki = '0; mfc_s = '0; mfc_t = '0; cub_s = '0; cub_t = '0;
    obj_wr = 1'b0; obj_sel = 2'h0; obj_val = '0; error_cnt = 0; comparisons = 0;
    do_reset(); t_regs();
    t_torque();
    do_reset(); t_modes();
    do_reset(); t_integ();
    do_reset(); t_friction();
    do_reset(); t_ff_int();
    do_reset(); t_ff_src();
    stop_test();
  end
endmodule
